// ---- ppc_regs.svh ----
// register map, field codes and masks of the parallel port control block
// assumes a 16-bit register port with byte addresses on an 8-bit address bus
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

`define PPC_CTRL_ADDR 8'h00
`define PPC_STAT_ADDR 8'h04
`define PPC_CTRL_RESET 16'h0000
// bits 14 and 4 are unimplemented
`define PPC_CTRL_WMASK 16'hBFEF
`define PPC_SHARE_SEPARATE 2'h0
`define PPC_SHARE_LOW8 2'h1
`define PPC_SHARE_FULL16 2'h2
`define PPC_SHARE_RESERVED 2'h3
`define PPC_CSF_SELECT 2'h2
`define PPC_UPPER_ADDR_MASK 16'h0700
`define PPC_FULL_ADDR_MASK 16'hFFFF
`define PPC_STAT_BUSY 0
`define PPC_STAT_HALTED 1
`define PPC_STAT_RSV_SHARE 2

`endif

// ---- ppc_pkg.sv ----
// types shared by the parallel port control block
// assumes nothing beyond a SystemVerilog compiler
package ppc_pkg;
    typedef enum logic [1:0] {
        PPC_ST_IDLE = 2'b00,
        PPC_ST_ALO = 2'b01,
        PPC_ST_AHI = 2'b10,
        PPC_ST_DATA = 2'b11
    } ppc_state_e;

    typedef struct packed {
        logic port_on;
        logic rsv14;
        logic halt_in_idle;
        logic [1:0] addr_data_share_sel;
        logic byte_sel_pin_on;
        logic write_strobe_pin_on;
        logic read_strobe_pin_on;
        logic [1:0] chip_select_function;
        logic latch_strobe_polarity;
        logic rsv4;
        logic select_one_polarity;
        logic byte_sel_polarity;
        logic write_strobe_polarity;
        logic read_strobe_polarity;
    } ppc_ctrl_s;

    typedef struct packed {
        logic write;
        logic byte_sel;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ppc_req_s;

    typedef struct packed {
        logic [7:0] data;
        logic data_oe;
        logic [15:0] addr;
        logic [15:0] addr_oe;
        logic byte_sel;
        logic byte_sel_oe;
        logic wr;
        logic wr_oe;
        logic rd;
        logic rd_oe;
        logic cs;
        logic cs_oe;
        logic all;
        logic all_oe;
        logic alh;
        logic alh_oe;
    } ppc_pins_s;
endpackage

// ---- ppc_parallel_port_control.sv ----
// parallel port control register and a small bus cycle engine behind it
// assumes synchronous inputs on I_REF_CLK (25 MHz) and a pin pad that
// resolves each pin from its value and output enable
//
// Implementation choices: the register addresses and the strobed register port.
`include "ppc_regs.svh"

module ppc_parallel_port_control
    import ppc_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic [7:0] I_ADDR,
    input wire logic [15:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [15:0] O_RDATA,
    input wire logic I_IDLE,
    input wire logic I_REQ_VALID,
    input wire ppc_req_s I_REQ,
    output logic O_REQ_READY,
    output logic O_RSP_VALID,
    output logic [7:0] O_RSP_DATA,
    input wire logic [7:0] I_PORT_DATA_LINES,
    output logic [7:0] O_PORT_DATA_LINES,
    output logic O_PORT_DATA_LINES_OE,
    output logic [15:0] O_PORT_ADDRESS_LINES,
    output logic [15:0] O_PORT_ADDRESS_LINES_OE,
    output logic O_BYTE_SEL_PIN,
    output logic O_BYTE_SEL_PIN_OE,
    output logic O_WRITE_STROBE_PIN,
    output logic O_WRITE_STROBE_PIN_OE,
    output logic O_READ_STROBE_PIN,
    output logic O_READ_STROBE_PIN_OE,
    output logic O_SELECT_ONE_PIN,
    output logic O_SELECT_ONE_PIN_OE,
    output logic O_LOW_LATCH_STROBE,
    output logic O_LOW_LATCH_STROBE_OE,
    output logic O_HIGH_LATCH_STROBE,
    output logic O_HIGH_LATCH_STROBE_OE
);

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    // pin level for an active flag: polarity set means active high
    function automatic logic pin_level(input logic active, input logic pol);
        return pol ? active : ~active;
    endfunction

    ppc_ctrl_s ctrl_reg;
    ppc_req_s req_reg;
    ppc_req_s req_next;
    ppc_state_e state_reg;
    ppc_state_e state_next;
    ppc_pins_s pins_reg;
    ppc_pins_s pins_next;
    logic [15:0] rdata_reg;
    logic [15:0] status;
    logic rsp_valid_reg;
    logic [7:0] rsp_data_reg;
    logic run;
    logic accept;
    logic [1:0] share;

    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);

    assign share = ctrl_reg.addr_data_share_sel;
    assign run = ctrl_reg.port_on & ~(ctrl_reg.halt_in_idle & I_IDLE);
    assign O_REQ_READY = run & (state_reg == PPC_ST_IDLE)
        & (share != `PPC_SHARE_RESERVED);
    assign accept = I_REQ_VALID & O_REQ_READY;

    // --------------------------------------------------------------
    // register port
    // --------------------------------------------------------------
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            ctrl_reg <= ppc_ctrl_s'(`PPC_CTRL_RESET);
        end else if (I_WR && I_ADDR == `PPC_CTRL_ADDR) begin
            ctrl_reg <= ppc_ctrl_s'(I_WDATA & `PPC_CTRL_WMASK);
        end
    end

    always_comb begin
        status = 16'h0000;
        status[`PPC_STAT_BUSY] = state_reg != PPC_ST_IDLE;
        status[`PPC_STAT_HALTED] = ctrl_reg.port_on & ~run;
        status[`PPC_STAT_RSV_SHARE] = share == `PPC_SHARE_RESERVED;
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            rdata_reg <= 16'h0000;
        end else if (I_RD) begin
            unique case (I_ADDR)
                `PPC_CTRL_ADDR: rdata_reg <= ctrl_reg;
                `PPC_STAT_ADDR: rdata_reg <= status;
                default: rdata_reg <= 16'h0000;
            endcase
        end else begin
            rdata_reg <= 16'h0000;
        end
    end
    assign O_RDATA = rdata_reg;

    // --------------------------------------------------------------
    // bus cycle engine
    // --------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        if (!ctrl_reg.port_on) begin
            state_next = PPC_ST_IDLE;
        end else if (run) begin
            unique case (state_reg)
                PPC_ST_IDLE: begin
                    if (accept) begin
                        state_next = (share == `PPC_SHARE_SEPARATE)
                            ? PPC_ST_DATA : PPC_ST_ALO;
                    end
                end
                PPC_ST_ALO: begin
                    state_next = (share == `PPC_SHARE_FULL16)
                        ? PPC_ST_AHI : PPC_ST_DATA;
                end
                PPC_ST_AHI: state_next = PPC_ST_DATA;
                PPC_ST_DATA: state_next = PPC_ST_IDLE;
            endcase
        end
    end

    assign req_next = accept ? I_REQ : req_reg;

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            state_reg <= PPC_ST_IDLE;
            req_reg <= '0;
        end else begin
            state_reg <= state_next;
            req_reg <= req_next;
        end
    end

    // completion pulse; read data sampled while the read strobe is active
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= 8'h00;
        end else begin
            rsp_valid_reg <= run & (state_reg == PPC_ST_DATA);
            if (run && state_reg == PPC_ST_DATA && !req_reg.write) begin
                rsp_data_reg <= I_PORT_DATA_LINES;
            end
        end
    end
    assign O_RSP_VALID = rsp_valid_reg;
    assign O_RSP_DATA = rsp_data_reg;

    // --------------------------------------------------------------
    // pin decode, registered so pins line up with state_reg
    // --------------------------------------------------------------
    always_comb begin
        logic on;
        logic busy;
        logic lo;
        logic hi;
        logic dat;
        on = ctrl_reg.port_on;
        busy = state_next != PPC_ST_IDLE;
        lo = state_next == PPC_ST_ALO;
        hi = state_next == PPC_ST_AHI;
        dat = state_next == PPC_ST_DATA;
        pins_next = '0;
        pins_next.data = lo ? req_next.addr[7:0]
            : (hi ? req_next.addr[15:8] : req_next.wdata);
        pins_next.data_oe = on & (lo | hi | (dat & req_next.write));
        unique case (share)
            `PPC_SHARE_SEPARATE: begin
                pins_next.addr = req_next.addr;
                pins_next.addr_oe = (on & busy) ? `PPC_FULL_ADDR_MASK : 16'h0000;
            end
            `PPC_SHARE_LOW8: begin
                pins_next.addr = req_next.addr & `PPC_UPPER_ADDR_MASK;
                pins_next.addr_oe = (on & busy) ? `PPC_UPPER_ADDR_MASK : 16'h0000;
            end
            default: begin
                pins_next.addr = 16'h0000;
                pins_next.addr_oe = 16'h0000;
            end
        endcase
        pins_next.byte_sel = pin_level(dat & req_next.byte_sel,
            ctrl_reg.byte_sel_polarity);
        pins_next.byte_sel_oe = on & ctrl_reg.byte_sel_pin_on;
        pins_next.wr = pin_level(dat & req_next.write,
            ctrl_reg.write_strobe_polarity);
        pins_next.wr_oe = on & ctrl_reg.write_strobe_pin_on;
        pins_next.rd = pin_level(dat & ~req_next.write,
            ctrl_reg.read_strobe_polarity);
        pins_next.rd_oe = on & ctrl_reg.read_strobe_pin_on;
        pins_next.cs = pin_level(busy, ctrl_reg.select_one_polarity);
        pins_next.cs_oe = on & (ctrl_reg.chip_select_function == `PPC_CSF_SELECT);
        pins_next.all = pin_level(lo, ctrl_reg.latch_strobe_polarity);
        pins_next.all_oe = on & (share != `PPC_SHARE_SEPARATE);
        pins_next.alh = pin_level(hi, ctrl_reg.latch_strobe_polarity);
        pins_next.alh_oe = on & (share == `PPC_SHARE_FULL16);
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            pins_reg <= '0;
        end else begin
            pins_reg <= pins_next;
        end
    end

    assign O_PORT_DATA_LINES = pins_reg.data;
    assign O_PORT_DATA_LINES_OE = pins_reg.data_oe;
    assign O_PORT_ADDRESS_LINES = pins_reg.addr;
    assign O_PORT_ADDRESS_LINES_OE = pins_reg.addr_oe;
    assign O_BYTE_SEL_PIN = pins_reg.byte_sel;
    assign O_BYTE_SEL_PIN_OE = pins_reg.byte_sel_oe;
    assign O_WRITE_STROBE_PIN = pins_reg.wr;
    assign O_WRITE_STROBE_PIN_OE = pins_reg.wr_oe;
    assign O_READ_STROBE_PIN = pins_reg.rd;
    assign O_READ_STROBE_PIN_OE = pins_reg.rd_oe;
    assign O_SELECT_ONE_PIN = pins_reg.cs;
    assign O_SELECT_ONE_PIN_OE = pins_reg.cs_oe;
    assign O_LOW_LATCH_STROBE = pins_reg.all;
    assign O_LOW_LATCH_STROBE_OE = pins_reg.all_oe;
    assign O_HIGH_LATCH_STROBE = pins_reg.alh;
    assign O_HIGH_LATCH_STROBE_OE = pins_reg.alh_oe;

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------

    sequence s_low_phase;
        state_reg == PPC_ST_ALO && O_PORT_DATA_LINES == req_reg.addr[7:0];
    endsequence
    sequence s_high_phase;
        state_reg == PPC_ST_AHI && O_PORT_DATA_LINES == req_reg.addr[15:8];
    endsequence

    a_off_no_drive: assert property (
        !ctrl_reg.port_on |=> !O_PORT_DATA_LINES_OE && !O_SELECT_ONE_PIN_OE
            && !O_READ_STROBE_PIN_OE && !O_WRITE_STROBE_PIN_OE
            && state_reg == PPC_ST_IDLE)
        else $error("pins driven while port off");
    a_idle_halt: assert property (
        (ctrl_reg.port_on && ctrl_reg.halt_in_idle && I_IDLE)
            |=> $stable(state_reg) && !O_RSP_VALID)
        else $error("port advanced during idle halt");
    a_full_mux_seq: assert property (
        (accept && share == `PPC_SHARE_FULL16 && !ctrl_reg.halt_in_idle && !I_WR)
            |=> s_low_phase ##1 s_high_phase ##1 state_reg == PPC_ST_DATA)
        else $error("full address sharing sequence wrong");
    a_low_mux_pins: assert property (
        (accept && share == `PPC_SHARE_LOW8 && !ctrl_reg.halt_in_idle && !I_WR)
            |=> s_low_phase and (O_PORT_ADDRESS_LINES_OE == `PPC_UPPER_ADDR_MASK)
            ##1 state_reg == PPC_ST_DATA)
        else $error("low byte sharing wrong");
    a_separate_direct: assert property (
        (accept && share == `PPC_SHARE_SEPARATE && !ctrl_reg.halt_in_idle)
            |=> state_reg == PPC_ST_DATA && O_PORT_ADDRESS_LINES == req_reg.addr
            ##1 O_RSP_VALID)
        else $error("separate mode cycle wrong");
    a_reserved_share: assert property (
        share == `PPC_SHARE_RESERVED |-> !O_REQ_READY)
        else $error("reserved sharing accepted a request");
    a_byte_sel_en: assert property (
        O_BYTE_SEL_PIN_OE == $past(ctrl_reg.port_on && ctrl_reg.byte_sel_pin_on))
        else $error("byte select enable mismatch");
    a_write_en: assert property (
        O_WRITE_STROBE_PIN_OE
            == $past(ctrl_reg.port_on && ctrl_reg.write_strobe_pin_on))
        else $error("write strobe enable mismatch");
    a_read_en: assert property (
        O_READ_STROBE_PIN_OE == $past(ctrl_reg.port_on && ctrl_reg.read_strobe_pin_on))
        else $error("read strobe enable mismatch");
    a_select_func: assert property (
        O_SELECT_ONE_PIN_OE == $past(ctrl_reg.port_on
            && ctrl_reg.chip_select_function == `PPC_CSF_SELECT))
        else $error("select pin function mismatch");
    a_latch_pol: assert property (
        (state_reg == PPC_ST_DATA) |-> O_LOW_LATCH_STROBE
            == !$past(ctrl_reg.latch_strobe_polarity)
            && O_HIGH_LATCH_STROBE == !$past(ctrl_reg.latch_strobe_polarity))
        else $error("latch strobe idle level wrong");
    a_select_pol: assert property (
        (state_reg != PPC_ST_IDLE) |-> O_SELECT_ONE_PIN
            == $past(ctrl_reg.select_one_polarity))
        else $error("select pin active level wrong");
    a_unimpl_zero: assert property (
        (I_RD && I_ADDR == `PPC_CTRL_ADDR) |=> (O_RDATA & ~`PPC_CTRL_WMASK) == 16'h0000)
        else $error("unimplemented control bits read nonzero");
    a_strobe_pol: assert property (
        (state_reg == PPC_ST_DATA && !req_reg.write)
            |-> O_READ_STROBE_PIN == $past(ctrl_reg.read_strobe_polarity)
            && O_WRITE_STROBE_PIN == !$past(ctrl_reg.write_strobe_polarity))
        else $error("strobe active level wrong");

endmodule

// ---- ppc_far_side_model.sv ----
// far-side model: a one-byte peripheral hanging on the parallel port pins
// assumes the bench resolves nothing itself and hands over the strobe polarities
module ppc_far_side_model (
    input wire logic i_clk,
    input wire logic [7:0] i_dout,
    input wire logic i_doe,
    input wire logic i_wr,
    input wire logic i_wr_oe,
    input wire logic i_wr_pol,
    input wire logic i_rd,
    input wire logic i_rd_oe,
    input wire logic i_rd_pol,
    output logic [7:0] o_line
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem_reg = 8'h5A;
    logic [7:0] last_reg = 8'h00;
    logic wr_act;
    logic rd_act;
    assign wr_act = i_wr_oe && (i_wr === i_wr_pol);
    assign rd_act = i_rd_oe && (i_rd === i_rd_pol);
    // a released line toggles every cycle so a stale value never passes for data
    always_comb begin
        if (i_doe)
            o_line = i_dout;
        else if (rd_act)
            o_line = mem_reg;
        else
            o_line = ~last_reg;
    end
    always @(posedge i_clk) begin
        last_reg <= o_line;
        if (wr_act && i_doe) begin
            mem_reg <= i_dout;
        end
    end
endmodule

// ---- tb.sv ----
// self-checking bench of the parallel port control block
// assumes the far-side model file and the design package are compiled first
`include "ppc_regs.svh"
module tb
    import ppc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, wr_s, rd_s, idle, req_v, ready, rsp_v, doe;
    logic be, beoe, wrp, wroe, rdp, rdoe, cs, csoe, al, aloe, ah, ahoe;
    logic [7:0] addr, rsp_d, din, dout, mem_exp, rd_byte;
    logic [15:0] wdata, rdata, q, pa, paoe, ra;
    ppc_req_s req;
    ppc_ctrl_s cfg;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int seed;

    ppc_parallel_port_control i_ppc_parallel_port_control (
        .I_REF_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s),
        .I_RD(rd_s), .O_RDATA(rdata), .I_IDLE(idle), .I_REQ_VALID(req_v), .I_REQ(req),
        .O_REQ_READY(ready), .O_RSP_VALID(rsp_v), .O_RSP_DATA(rsp_d),
        .I_PORT_DATA_LINES(din), .O_PORT_DATA_LINES(dout), .O_PORT_DATA_LINES_OE(doe),
        .O_PORT_ADDRESS_LINES(pa), .O_PORT_ADDRESS_LINES_OE(paoe),
        .O_BYTE_SEL_PIN(be), .O_BYTE_SEL_PIN_OE(beoe), .O_WRITE_STROBE_PIN(wrp),
        .O_WRITE_STROBE_PIN_OE(wroe), .O_READ_STROBE_PIN(rdp), .O_READ_STROBE_PIN_OE(rdoe),
        .O_SELECT_ONE_PIN(cs), .O_SELECT_ONE_PIN_OE(csoe), .O_LOW_LATCH_STROBE(al),
        .O_LOW_LATCH_STROBE_OE(aloe), .O_HIGH_LATCH_STROBE(ah), .O_HIGH_LATCH_STROBE_OE(ahoe));
    ppc_far_side_model i_ppc_far_side_model (
        .i_clk(clk), .i_dout(dout), .i_doe(doe), .i_wr(wrp), .i_wr_oe(wroe),
        .i_wr_pol(cfg.write_strobe_polarity), .i_rd(rdp), .i_rd_oe(rdoe),
        .i_rd_pol(cfg.read_strobe_polarity), .o_line(din));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            final_report();
        end
    end

    // --------------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------------
    function automatic logic act(input logic pin, input logic oe, input logic pol);
        return (oe === 1'b1) && (pin === pol);
    endfunction

    // cycles from accept to the completion pulse: the accept cycle, one per address phase, then data
    function automatic int exp_lat(input logic [1:0] sh);
        return int'(sh) + 2;
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #5 q = rdata;
    endtask

    // writes cfg, lets the one-cycle lag pass, checks pins at rest
    task automatic set_cfg();
        wr(`PPC_CTRL_ADDR, cfg);
        repeat (2) @(posedge clk);
        #5;
        chk(rdoe, cfg.read_strobe_pin_on);
        chk(wroe, cfg.write_strobe_pin_on);
        chk(beoe, cfg.byte_sel_pin_on);
        chk(csoe, cfg.chip_select_function == `PPC_CSF_SELECT);
        if (rdoe) chk(rdp, !cfg.read_strobe_polarity);
        if (wroe) chk(wrp, !cfg.write_strobe_polarity);
        if (beoe) chk(be, !cfg.byte_sel_polarity);
        if (csoe) chk(cs, !cfg.select_one_polarity);
        if (aloe) chk(al, !cfg.latch_strobe_polarity);
        if (ahoe) chk(ah, !cfg.latch_strobe_polarity);
    endtask

    task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
        int lat;
        logic [1:0] sh;
        logic wr_on;
        logic rd_on;
        logic cs_on;
        sh = cfg.addr_data_share_sel;
        lat = exp_lat(sh);
        wr_on = cfg.write_strobe_pin_on;
        rd_on = cfg.read_strobe_pin_on;
        cs_on = cfg.chip_select_function == `PPC_CSF_SELECT;
        @(posedge clk);
        req <= '{write: w, byte_sel: a[0], addr: a, wdata: d};
        req_v <= 1'b1;
        #5 chk(ready, 1'b1);
        @(posedge clk);
        req_v <= 1'b0;
        for (int k = 1; k <= lat; k++) begin
            #5;
            chk(rsp_v, k == lat);
            if (k == 1) chk(act(al, aloe, cfg.latch_strobe_polarity), sh != 2'h0);
            if (k == 1 && sh != 2'h0) chk(dout, a[7:0]);
            if (k == 2) chk(act(ah, ahoe, cfg.latch_strobe_polarity), sh == 2'h2);
            if (k == 2 && sh == 2'h2) chk(dout, a[15:8]);
            if (k == lat - 1) begin
                chk(doe, w);
                if (w) chk(dout, d);
                if (sh == 2'h0) chk(paoe, `PPC_FULL_ADDR_MASK);
                if (sh == 2'h0) chk(pa, a);
                if (sh == 2'h1) chk(paoe, `PPC_UPPER_ADDR_MASK);
                if (sh == 2'h1) chk(pa & 16'h0700, a & 16'h0700);
                chk(act(be, beoe, cfg.byte_sel_polarity), cfg.byte_sel_pin_on && a[0]);
                if (w) chk(act(wrp, wroe, cfg.write_strobe_polarity), wr_on);
                if (!w) chk(act(rdp, rdoe, cfg.read_strobe_polarity), rd_on);
                chk(act(cs, csoe, cfg.select_one_polarity), cs_on);
            end
            if (k == lat && !w && cfg.read_strobe_pin_on) chk(rsp_d, mem_exp);
            @(posedge clk);
        end
        if (w && cfg.write_strobe_pin_on) mem_exp = d;
    endtask

    // --------------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------------
    initial begin
        seed = 32'hc49d;
        rst = 1'b1;
        wr_s = 1'b0;
        rd_s = 1'b0;
        idle = 1'b0;
        req_v = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        req = '0;
        cfg = '0;
        mem_exp = 8'h5A;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(`PPC_CTRL_ADDR);
        chk(q, `PPC_CTRL_RESET);
        wr(`PPC_CTRL_ADDR, 16'hFFFF);
        rd(`PPC_CTRL_ADDR);
        chk(q, `PPC_CTRL_WMASK);
        wr(8'h08, 16'h0000);
        rd(8'h08);
        chk(q, 16'h0000);
        rd(`PPC_CTRL_ADDR);
        chk(q, `PPC_CTRL_WMASK);
        done("registers");
        wr(`PPC_CTRL_ADDR, 16'h0700);
        req_v <= 1'b1;
        idle <= 1'b1;
        repeat (3) begin
            @(posedge clk);
            #5 chk({ready, rsp_v, rdoe, wroe}, 4'h0);
        end
        wr(`PPC_CTRL_ADDR, 16'h9F00);
        @(posedge clk);
        #5 chk(ready, 1'b0);
        rd(`PPC_STAT_ADDR);
        chk(q, 16'(1 << `PPC_STAT_RSV_SHARE));
        wr(`PPC_CTRL_ADDR, 16'hA700);
        rd(`PPC_STAT_ADDR);
        chk(q, 16'(1 << `PPC_STAT_HALTED));
        chk({ready, rsp_v}, 2'h0);
        @(posedge clk);
        req_v <= 1'b0;
        idle <= 1'b0;
        done("refusals");
        for (int i = 0; i < 30; i++) begin
            cfg = (i < 3) ? 16'h87AF : 16'h8780;
            cfg.addr_data_share_sel = 2'(i % 3);
            if (i >= 6) begin
                cfg = 16'($random(seed));
                cfg.port_on = 1'b1;
                cfg.halt_in_idle = 1'b0;
                cfg.rsv14 = 1'b0;
                cfg.rsv4 = 1'b0;
                if (cfg.addr_data_share_sel == 2'h3) cfg.addr_data_share_sel = 2'h2;
            end
            idle <= 1'($random(seed));
            set_cfg();
            ra = 16'($random(seed));
            rd_byte = 8'($random(seed));
            xfer(1'b1, ra, rd_byte);
            xfer(1'b0, ra, 8'h00);
        end
        done("transfers");
        final_report();
    end
endmodule
